// ---- hw/cpu_sideband.sv ----
/*
 Module-side sideband logic: error out, legacy control inputs, stop-clock
 power state, regulator power good and the thermal sensor with its alert.
 Assumes the bridge drives its lines synchronously to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband
    import sideband_pkg::*;
#(
    parameter int VR_SETTLE = VR_SETTLE_CYC
)(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Processor core side
    input wire logic core_fp_error_in,
    input wire logic [ADDR_W-1:0] core_addr_in,
    output logic [ADDR_W-1:0] bus_addr_out,
    output logic core_ignore_err_out,
    output logic core_init_out,
    output logic core_irq_out,
    output logic core_nmi_out,
    output logic core_smi_out,
    output logic core_clk_run_out,
    // Bridge sideband lines
    output logic numeric_error_n_out,
    input wire logic ignore_numeric_error_n_in,
    input wire logic init_n_in,
    input wire logic maskable_irq_req_in,
    input wire logic nmi_in,
    input wire logic addr_bit20_mask_n_in,
    input wire logic mgmt_interrupt_n_in,
    input wire logic stop_clock_req_n_in,
    // Power management
    input wire logic suspend_status_n_in,
    input wire logic regulator_enable_in,
    input wire logic bridge_power_ok_in,
    output logic regulator_power_good_out,
    output logic quick_start_out,
    // Thermal sensor
    input wire logic [7:0] temp_in,
    input wire logic smbus_clock_in,
    input wire logic smbus_data_in,
    output logic smbus_data_out,
    output logic smbus_data_oe_out,
    output logic thermal_alert_n_out,
    output logic thermal_alert_n_oe_out
);
    // ****************************************
    // Error out and legacy inputs
    // ****************************************
    cpu_state_t cpu_state;
    logic [31:0] vr_cnt;
    logic sda_oe;
    logic [7:0] trip;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            numeric_error_n_out <= 1'b1;
            core_ignore_err_out <= 1'b0;
            core_init_out <= 1'b0;
            core_irq_out <= 1'b0;
            core_nmi_out <= 1'b0;
            core_smi_out <= 1'b0;
            bus_addr_out <= '0;
        end else if (ce_in) begin
            numeric_error_n_out <= !core_fp_error_in;
            core_ignore_err_out <= !ignore_numeric_error_n_in;
            core_init_out <= !init_n_in;
            core_irq_out <= maskable_irq_req_in;
            core_nmi_out <= nmi_in;
            core_smi_out <= !mgmt_interrupt_n_in;
            bus_addr_out <= core_addr_in;
            if (!addr_bit20_mask_n_in) begin
                bus_addr_out[WRAP_BIT] <= 1'b0;
            end
        end
    end
    // ****************************************
    // Stop-clock power state
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cpu_state <= CPU_RUN;
        end else if (ce_in) begin
            unique case (cpu_state)
                CPU_RUN: if (!stop_clock_req_n_in) cpu_state <= CPU_QUICK_START;
                CPU_QUICK_START: if (stop_clock_req_n_in) cpu_state <= CPU_RUN;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            quick_start_out <= 1'b0;
            core_clk_run_out <= 1'b0;
        end else if (ce_in) begin
            quick_start_out <= (cpu_state == CPU_QUICK_START);
            core_clk_run_out <= (cpu_state == CPU_RUN) && suspend_status_n_in
                && bridge_power_ok_in;
        end
    end
    // ****************************************
    // Regulator power good
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            vr_cnt <= '0;
            regulator_power_good_out <= 1'b0;
        end else if (ce_in) begin
            if (!regulator_enable_in) begin
                vr_cnt <= '0;
                regulator_power_good_out <= 1'b0;
            end else if (vr_cnt < 32'(VR_SETTLE)) begin
                vr_cnt <= vr_cnt + 32'h1;
            end else begin
                regulator_power_good_out <= 1'b1;
            end
        end
    end
    // ****************************************
    // Thermal sensor and alert
    // ****************************************
    sensor_smbus u_sensor (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .scl_in(smbus_clock_in),
        .sda_in(smbus_data_in),
        .sda_oe_out(sda_oe),
        .temp_in(temp_in),
        .trip_out(trip)
    );
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            smbus_data_oe_out <= 1'b0;
            smbus_data_out <= 1'b0;
            thermal_alert_n_out <= 1'b0;
            thermal_alert_n_oe_out <= 1'b0;
        end else if (ce_in) begin
            smbus_data_out <= 1'b0;
            smbus_data_oe_out <= sda_oe;
            thermal_alert_n_out <= 1'b0;
            thermal_alert_n_oe_out <= (temp_in >= trip);
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    a_numeric_error_n: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (numeric_error_n_out == !$past(core_fp_error_in)))
        else $error("numeric error not passed out");
    a_a20: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !addr_bit20_mask_n_in) |=> !bus_addr_out[WRAP_BIT])
        else $error("address bit 20 not masked");
    a_a20_pass: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in && addr_bit20_mask_n_in) |=> (bus_addr_out == $past(core_addr_in)))
        else $error("address altered without mask");
    a_stop_clock_req_n: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in && !stop_clock_req_n_in) ##1 (ce_in && !stop_clock_req_n_in)
        |=> quick_start_out)
        else $error("quick start not entered");
    a_stop_clock_req_n_exit: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && stop_clock_req_n_in) ##1 (ce_in && stop_clock_req_n_in) |=> !quick_start_out)
        else $error("quick start not left");
    a_pgood_off: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !regulator_enable_in) |=> !regulator_power_good_out)
        else $error("power good while regulator off");
    a_alert: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (thermal_alert_n_oe_out == ($past(temp_in) >= $past(trip))))
        else $error("thermal alert wrong");
    a_od: assert property (@(posedge clk_in) disable iff (srst_in)
        !smbus_data_out && !thermal_alert_n_out)
        else $error("open-drain line driven high");

    // ****************************************
    // Input paths, core clock run, power good and clock enable
    // ****************************************
    a_ign: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (core_ignore_err_out == !$past(ignore_numeric_error_n_in)))
        else $error("ignore error not passed in");

    a_init: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (core_init_out == !$past(init_n_in)))
        else $error("init not passed in");

    a_irq: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (core_irq_out == $past(maskable_irq_req_in)))
        else $error("interrupt request not passed in");

    a_nmi: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (core_nmi_out == $past(nmi_in)))
        else $error("non-maskable interrupt not passed in");

    a_smi: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in) |=> (core_smi_out == !$past(mgmt_interrupt_n_in)))
        else $error("management interrupt not passed in");

    a_qs_no_clk: assert property (@(posedge clk_in) disable iff (srst_in)
        quick_start_out |-> !core_clk_run_out)
        else $error("core clock runs in quick start");

    a_clk_susp: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in && !suspend_status_n_in) |=> !core_clk_run_out)
        else $error("core clock runs in suspend");

    a_clk_pwrok: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in && !bridge_power_ok_in) |=> !core_clk_run_out)
        else $error("core clock runs without power ok");

    a_pgood_on: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && !srst_in && regulator_enable_in && vr_cnt == 32'(VR_SETTLE))
        |=> regulator_power_good_out)
        else $error("power good late");

    a_numeric_error_n_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!ce_in && !srst_in) |=> $stable(numeric_error_n_out))
        else $error("numeric error moved while disabled");

    a_addr_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!ce_in && !srst_in) |=> $stable(bus_addr_out))
        else $error("address moved while disabled");

    a_qs_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!ce_in && !srst_in) |=> $stable(quick_start_out))
        else $error("quick start moved while disabled");

    a_pgood_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!ce_in && !srst_in) |=> $stable(regulator_power_good_out))
        else $error("power good moved while disabled");

    a_alert_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (!ce_in && !srst_in) |=> $stable(thermal_alert_n_oe_out))
        else $error("thermal alert moved while disabled");
endmodule // cpu_sideband
`default_nettype wire

// ---- hw/sideband_pkg.sv ----
/*
 Constants for the processor module sideband and power signalling block.
 Assumes one 100 MHz clock; all pins sampled synchronously to it.
*/
// What this block does
// - The processor's numeric error is passed out on the active-low numeric error line.
// - While the address-20 mask is asserted, addresses wrap at the one megabyte boundary.
// - Power good goes high once the regulator is stable and reads low otherwise.
// - The SMBus clock and data lines serve only the thermal sensor address.
// - The thermal sensor signals its interrupt on an active-low open-drain output.
package sideband_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWROK_LEAD_MS = 1;
    localparam int PWROK_LEAD_CYC = (PWROK_LEAD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VR_SETTLE_US = 100;
    localparam int VR_SETTLE_CYC = (VR_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ****************************************
    // Addresses and SMBus
    // ****************************************
    localparam int ADDR_W = 32;
    localparam int WRAP_BIT = 20;
    localparam logic [6:0] SENSOR_ADDR = 7'h4e;
    localparam logic [7:0] TEMP_RESET = 8'h19;
    localparam logic [7:0] TRIP_RESET = 8'h50;
    // ****************************************
    // Processor power states and SMBus responder states
    // ****************************************
    typedef enum logic [1:0] {
        CPU_RUN = 2'b01,
        CPU_QUICK_START = 2'b10
    } cpu_state_t;
    typedef enum logic [6:0] {
        SM_IDLE = 7'h01,
        SM_ADDR = 7'h02,
        SM_AACK = 7'h04,
        SM_RD = 7'h08,
        SM_RACK = 7'h10,
        SM_WR = 7'h20,
        SM_WACK = 7'h40
    } smb_state_t;
endpackage

// ---- hw/sensor_smbus.sv ----
/*
 Thermal sensor SMBus responder: answers only its own address.
 Assumes SMBus clock and data sampled synchronously at clk_in, much faster than the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_smbus
    import sideband_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    // Sensor data
    input wire logic [7:0] temp_in,
    output logic [7:0] trip_out
);
    // ****************************************
    // Bus edge and condition detect
    // ****************************************
    logic scl_q, sda_q;
    smb_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rd_mode;
    wire scl_rise = scl_in && !scl_q;
    wire scl_fall = !scl_in && scl_q;
    wire start_c = scl_in && scl_q && sda_q && !sda_in;
    wire stop_c = scl_in && scl_q && !sda_q && sda_in;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce_in) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end
    // ****************************************
    // Protocol engine
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= SM_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rd_mode <= 1'b0;
            sda_oe_out <= 1'b0;
            trip_out <= TRIP_RESET;
        end else if (ce_in) begin
            if (start_c) begin
                state <= SM_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (stop_c) begin
                state <= SM_IDLE;
                sda_oe_out <= 1'b0;
            end else begin
                unique case (state)
                    SM_IDLE: sda_oe_out <= 1'b0;
                    SM_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            // Other addresses stay reserved: no answer
                            if (shift[7:1] == SENSOR_ADDR) begin
                                sda_oe_out <= 1'b1;
                                rd_mode <= shift[0];
                                state <= SM_AACK;
                            end else begin
                                state <= SM_IDLE;
                            end
                        end
                    end
                    SM_AACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rd_mode) begin
                                shift <= {temp_in[6:0], 1'b0};
                                sda_oe_out <= !temp_in[7];
                                state <= SM_RD;
                            end else begin
                                sda_oe_out <= 1'b0;
                                state <= SM_WR;
                            end
                        end
                    end
                    SM_RD: begin
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == 4'h7) begin
                                sda_oe_out <= 1'b0;
                                state <= SM_RACK;
                            end else begin
                                sda_oe_out <= !shift[7];
                                shift <= {shift[6:0], 1'b0};
                            end
                        end
                    end
                    SM_RACK: begin
                        if (scl_rise) begin
                            state <= sda_in ? SM_IDLE : SM_AACK;
                        end
                    end
                    SM_WR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_in};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            trip_out <= shift;
                            sda_oe_out <= 1'b1;
                            state <= SM_WACK;
                        end
                    end
                    SM_WACK: begin
                        if (scl_fall) begin
                            sda_oe_out <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= SM_WR;
                        end
                    end
                endcase
            end
        end
    end
    a_ack_only_own: assert property (@(posedge clk_in) disable iff (srst_in)
        (ce_in && state == SM_ADDR && scl_fall && bit_cnt == 4'h8 && shift[7:1] != SENSOR_ADDR)
        |=> !sda_oe_out)
        else $error("ack given to foreign address");
endmodule // sensor_smbus
`default_nettype wire

// ---- testbench/bridge_model.sv ----
/*
 Bridge and power electronics model: sideband lines, power-OK and SMBus master.
 Assumes the bench calls its tasks; every line changes just after clk_in rises.
*/
`timescale 1ns/1ps
`default_nettype none
module bridge_model #(
    parameter int PWROK_LEAD = 8
)(
    // Clock
    input wire logic clk_in,
    // Sideband and power lines, wire levels
    output logic [8:0] lines_out,
    output logic bridge_power_ok_out,
    // SMBus
    output logic scl_out,
    output logic sda_pull_out,
    input wire logic sda_in
);
    // ****************************************
    // Power-up and lines
    // ****************************************
    initial begin
        lines_out = 9'h19e;
        bridge_power_ok_out = 1'b0;
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
        repeat (PWROK_LEAD) @(posedge clk_in);
        bridge_power_ok_out <= 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Open-drain lines pulled low or released to the pull-up
    task automatic set_lines(input logic [8:0] v);
        @(posedge clk_in);
        lines_out <= v;
    endtask
    task automatic set_power_ok(input logic v);
        @(posedge clk_in);
        bridge_power_ok_out <= v;
    endtask
    // ****************************************
    // SMBus master
    // ****************************************
    task automatic smb_bit(input logic b, output logic seen);
        @(posedge clk_in);
        sda_pull_out <= !b;
        tick(4);
        scl_out <= 1'b1;
        tick(2);
        seen = sda_in;
        tick(2);
        scl_out <= 1'b0;
    endtask
    task automatic smb_start();
        tick(4);
        sda_pull_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
    endtask
    task automatic smb_stop();
        @(posedge clk_in);
        sda_pull_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_pull_out <= 1'b0;
    endtask
    task automatic smb_byte(input logic [7:0] tx, input logic ack_in,
                            output logic [7:0] rx, output logic ack_seen);
        for (int i = 7; i >= 0; i--) smb_bit(tx[i], rx[i]);
        smb_bit(ack_in, ack_seen);
    endtask
endmodule // bridge_model
`default_nettype wire

// ---- testbench/cpu_sideband_test.sv ----
/*
 Self-checking bench for cpu_sideband with the bridge model on its far side.
 Assumes VR_SETTLE of 5 and a pull-up on the SMBus data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_test;
    import sideband_pkg::*;
    localparam int SETTLE = 5;
    logic clk_in, srst_in, ce_in, fp_err, pwrok, scl, sda_pull, sda_wire;
    logic [31:0] addr, bus_addr;
    logic [7:0] temp, rx;
    logic [8:0] lines;
    logic ign, init, irq, nmi, smi, clk_run, numeric_error_n_n, pgood, qs;
    logic sda_o, sda_oe, alert_n, alert_oe, ack;
    int failures = 0;
    int compares = 0;
    assign sda_wire = !(sda_pull | sda_oe);
    bridge_model model_u (.clk_in(clk_in), .lines_out(lines), .bridge_power_ok_out(pwrok),
        .scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda_wire));
    cpu_sideband #(.VR_SETTLE(SETTLE)) dut_u (.clk_in(clk_in), .srst_in(srst_in),
        .ce_in(ce_in), .core_fp_error_in(fp_err), .core_addr_in(addr),
        .bus_addr_out(bus_addr), .core_ignore_err_out(ign), .core_init_out(init),
        .core_irq_out(irq), .core_nmi_out(nmi), .core_smi_out(smi),
        .core_clk_run_out(clk_run), .numeric_error_n_out(numeric_error_n_n),
        .ignore_numeric_error_n_in(lines[8]), .init_n_in(lines[7]),
        .maskable_irq_req_in(lines[6]), .nmi_in(lines[5]), .addr_bit20_mask_n_in(lines[4]),
        .mgmt_interrupt_n_in(lines[3]), .stop_clock_req_n_in(lines[2]),
        .suspend_status_n_in(lines[1]), .regulator_enable_in(lines[0]),
        .bridge_power_ok_in(pwrok), .regulator_power_good_out(pgood),
        .quick_start_out(qs), .temp_in(temp), .smbus_clock_in(scl),
        .smbus_data_in(sda_wire), .smbus_data_out(sda_o), .smbus_data_oe_out(sda_oe),
        .thermal_alert_n_out(alert_n), .thermal_alert_n_oe_out(alert_oe));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset();
        check_bit("numeric error", 1'b1, numeric_error_n_n);
        check_bit("power good", 1'b0, pgood);
        check_bit("sda oe", 1'b0, sda_oe);
        check_bit("alert oe", 1'b0, alert_oe);
        $display("test reset done");
    endtask
    task automatic test_legacy();
        model_u.set_lines(9'h066);
        fp_err <= 1'b1;
        addr <= 32'h0012_3456;
        wait_cyc(2);
        check_bit("numeric error", 1'b0, numeric_error_n_n);
        check_word("wrapped addr", 32'h0002_3456, bus_addr);
        check_word("legacy", 32'h1f, {27'h0, ign, init, irq, nmi, smi});
        model_u.set_lines(9'h19e);
        fp_err <= 1'b0;
        wait_cyc(2);
        check_bit("numeric error", 1'b1, numeric_error_n_n);
        check_word("addr", 32'h0012_3456, bus_addr);
        check_word("legacy", 32'h0, {27'h0, ign, init, irq, nmi, smi});
        @(posedge clk_in);
        ce_in <= 1'b0;
        fp_err <= 1'b1;
        wait_cyc(3);
        check_bit("frozen error", 1'b1, numeric_error_n_n);
        @(posedge clk_in);
        ce_in <= 1'b1;
        fp_err <= 1'b0;
        $display("test legacy done");
    endtask
    task automatic test_stop_clock();
        model_u.set_lines(9'h19a);
        wait_cyc(3);
        check_bit("quick start", 1'b1, qs);
        check_bit("clock run", 1'b0, clk_run);
        wait_cyc(20);
        check_bit("quick start held", 1'b1, qs);
        model_u.set_lines(9'h19e);
        wait_cyc(3);
        check_bit("quick start", 1'b0, qs);
        check_bit("clock run", 1'b1, clk_run);
        $display("test stop clock done");
    endtask
    task automatic test_regulator();
        model_u.set_lines(9'h19d);
        wait_cyc(3);
        check_bit("power good early", 1'b0, pgood);
        check_bit("clock run", 1'b0, clk_run);
        wait_cyc(SETTLE + 2);
        check_bit("power good", 1'b1, pgood);
        model_u.set_lines(9'h19e);
        wait_cyc(2);
        check_bit("power good off", 1'b0, pgood);
        $display("test regulator done");
    endtask
    task automatic test_smbus();
        model_u.smb_start();
        model_u.smb_byte({SENSOR_ADDR, 1'b0}, 1'b1, rx, ack);
        check_bit("write addr ack", 1'b0, ack);
        model_u.smb_byte(8'h30, 1'b1, rx, ack);
        check_bit("trip ack", 1'b0, ack);
        model_u.smb_stop();
        model_u.smb_start();
        model_u.smb_byte({SENSOR_ADDR, 1'b1}, 1'b1, rx, ack);
        check_bit("read addr ack", 1'b0, ack);
        model_u.smb_byte(8'hff, 1'b1, rx, ack);
        check_word("temperature", 32'h2c, {24'h0, rx});
        model_u.smb_stop();
        model_u.smb_start();
        model_u.smb_byte(8'h9f, 1'b1, rx, ack);
        check_bit("foreign addr", 1'b1, ack);
        check_bit("sda level", 1'b0, sda_o);
        model_u.smb_stop();
        @(posedge clk_in);
        temp <= 8'h30;
        wait_cyc(3);
        check_bit("alert at trip", 1'b1, alert_oe);
        check_bit("alert level", 1'b0, alert_n);
        @(posedge clk_in);
        temp <= 8'h2f;
        wait_cyc(3);
        check_bit("alert below trip", 1'b0, alert_oe);
        $display("test smbus done");
    endtask
    task automatic test_mid_reset();
        @(posedge clk_in);
        srst_in <= 1'b1;
        temp <= 8'h30;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_cyc(2);
        check_bit("alert after reset", 1'b0, alert_oe);
        check_bit("power good after reset", 1'b0, pgood);
        check_bit("numeric error after reset", 1'b1, numeric_error_n_n);
        check_word("addr after reset", 32'h0012_3456, bus_addr);
        check_bit("clock run after reset", 1'b1, clk_run);
        model_u.set_power_ok(1'b0);
        wait_cyc(2);
        check_bit("clock run no power ok", 1'b0, clk_run);
        model_u.set_power_ok(1'b1);
        wait_cyc(2);
        check_bit("clock run power ok", 1'b1, clk_run);
        $display("test mid reset done");
    endtask
    // ****************************************
    // Run
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        srst_in = 1'b1;
        ce_in = 1'b1;
        fp_err = 1'b0;
        addr = 32'h0;
        temp = 8'h2c;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        wait_cyc(4);
        test_reset();
        test_legacy();
        test_stop_clock();
        test_regulator();
        test_smbus();
        test_mid_reset();
        end_of_test();
    end
endmodule // cpu_sideband_test
`default_nettype wire
